// ===== hw/iprb_pkg.sv
// constants for the seven-port i/o register bank and output cell groups
package iprb_pkg;
    localparam int NPORT = 7;
    localparam int PW    = 8;
    localparam int AW    = 8;               // 256-byte window

    // per-port offsets, index 0 is port a ... index 6 is port g
    localparam logic [6:0][7:0] OFS_LEVEL =
        {8'h41, 8'h40, 8'h30, 8'h11, 8'h10, 8'h01, 8'h00};
    localparam logic [6:0][7:0] OFS_LATCH =
        {8'h45, 8'h44, 8'h34, 8'h15, 8'h14, 8'h05, 8'h04};
    localparam logic [6:0][7:0] OFS_DIR =
        {8'h47, 8'h46, 8'h36, 8'h17, 8'h16, 8'h07, 8'h06};
    localparam logic [6:0][7:0] OFS_DRV =
        {8'h49, 8'h48, 8'h38, 8'h19, 8'h18, 8'h09, 8'h08};
    localparam logic [6:0][7:0] OFS_FUNC =
        {8'h43, 8'h42, 8'h32, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [6:0][7:0] OFS_ENST =
        {8'hFF, 8'h4C, 8'hFF, 8'hFF, 8'h1C, 8'h0D, 8'h0C};
    localparam logic [6:0][7:0] OFS_ICELL =
        {8'hFF, 8'hFF, 8'hFF, 8'h1A, 8'hFF, 8'h0B, 8'h0A};

    // which ports own which register kind
    localparam logic [6:0] HAS_FUNC  = 7'h70;   // e, f, g
    localparam logic [6:0] HAS_OD    = 7'h5B;   // a, b, d, e, g
    localparam logic [6:0] HAS_ENST  = 7'h27;   // a, b, c, f
    localparam logic [6:0] HAS_ICELL = 7'h0B;   // a, b, d

    localparam logic [7:0] OFS_CELLS_A = 8'h20;
    localparam logic [7:0] OFS_CELLS_B = 8'h21;
    localparam logic [7:0] OFS_GUARD_A = 8'h22;
    localparam logic [7:0] OFS_GUARD_B = 8'h23;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [7:0] RST_DRV   = 8'h00;
    localparam logic [7:0] RST_FUNC  = 8'h00;
    localparam logic [7:0] RST_GUARD = 8'h00;
    localparam logic [7:0] RST_CELLS = 8'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;
endpackage

// ===== hw/iprb_port_pin.sv
// one port's pin synchroniser and registered pin driver
`timescale 1ns/100ps
module iprb_port_pin #(
    parameter int W        = 8,
    parameter bit HAS_OD   = 1'b1,
    parameter bit HAS_FUNC = 1'b0
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] drv,
    input  wire logic [W-1:0] func,
    input  wire logic [W-1:0] addr_bits,
    output logic      [W-1:0] level,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] addr_mode;
    logic [W-1:0] od_mode;
    logic [W-1:0] oe_next;
    logic [W-1:0] out_next;

    // two-stage synchroniser; only level_reg is read by the bank
    always_ff @(posedge mclk)
    begin
        meta_reg  <= pin_in;
        level_reg <= meta_reg;
    end
    assign level = level_reg;

    // ports without these features see the bits forced off
    assign addr_mode = HAS_FUNC ? func : '0;
    assign od_mode   = HAS_OD ? drv : '0;

    // with the function bit clear, open-drain only drives low; a high bit releases the pin
    assign oe_next  = addr_mode | (dir & ~(od_mode & latch));
    assign out_next = (addr_mode & addr_bits)
                    | (~addr_mode & dir & ~od_mode & latch);

    // registered drivers, tri-stated from reset onward
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_oe  <= '0;
            pin_out <= '0;
        end
        else
        begin
            pin_oe  <= oe_next;
            pin_out <= out_next;
        end
    end

    odrain_low_a: assert property (@(posedge mclk) disable iff (rst)
        (HAS_OD && !addr_mode[0] && dir[0] && drv[0] && latch[0]) |=> !pin_oe[0])
        else $error("open-drain pin drove a high level");
    dir_input_a: assert property (@(posedge mclk) disable iff (rst)
        (!addr_mode[0] && !dir[0]) |=> !pin_oe[0])
        else $error("input pin was driven");
endmodule

// ===== hw/iprb_out_cells.sv
// one group of eight output cell flip-flops with cpu write guard
`timescale 1ns/100ps
module iprb_out_cells #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         cpu_wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] guard,
    input  wire logic         pld_load,
    input  wire logic [W-1:0] pld_data,
    output logic      [W-1:0] cells
);
    logic [W-1:0] cells_next;

    // cpu load wins over the array's own load in the same cycle
    always_comb
    begin
        cells_next = cells;
        if (cpu_wr)
            cells_next = (cells & guard) | (wdata & ~guard);
        else if (pld_load)
            cells_next = pld_data;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            cells <= iprb_pkg::RST_CELLS;
        else
            cells <= cells_next;
    end

    cell_guard_a: assert property (@(posedge mclk) disable iff (rst)
        cpu_wr |=> cells == (($past(cells) & $past(guard)) | ($past(wdata) & ~$past(guard))))
        else $error("guarded cell write mismatch");
endmodule

// ===== hw/iprb_bank.sv
// register bank for seven i/o ports and two output cell groups
`timescale 1ns/100ps
module iprb_bank #(
    parameter int W = iprb_pkg::PW
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  register_window_select,
    input  wire logic [7:0]            bus_addr,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    input  wire logic [W-1:0]          bus_wdata,
    output logic      [W-1:0]          bus_rdata,
    input  wire logic [6:0][W-1:0]     port_pin_in,
    output logic      [6:0][W-1:0]     port_pin_out,
    output logic      [6:0][W-1:0]     port_pin_oe,
    output logic      [W-1:0]          slew_fast_c,
    output logic      [W-1:0]          slew_fast_f,
    input  wire logic [W-1:0]          latched_addr,
    input  wire logic [W-1:0]          input_cell_a,
    input  wire logic [W-1:0]          input_cell_b,
    input  wire logic [W-1:0]          input_cell_d,
    input  wire logic                  pld_load_a,
    input  wire logic [W-1:0]          pld_data_a,
    input  wire logic                  pld_load_b,
    input  wire logic [W-1:0]          pld_data_b,
    output logic      [W-1:0]          cells_a,
    output logic      [W-1:0]          cells_b
);
    logic [6:0][W-1:0] latch_reg;
    logic [6:0][W-1:0] dir_reg;
    logic [6:0][W-1:0] drv_reg;
    logic [6:0][W-1:0] func_reg;
    logic [6:0][W-1:0] level;
    logic [6:0][W-1:0] icell;
    logic [W-1:0]      guard_a_reg;
    logic [W-1:0]      guard_b_reg;
    logic [W-1:0]      rdata_next;
    logic              wr_hit;
    logic              rd_hit;

    // every access is qualified by the window select from the decoder
    assign wr_hit = register_window_select & bus_wr;
    assign rd_hit = register_window_select & bus_rd;

    // input cell states of ports a, b and d; others never read
    always_comb
    begin
        icell    = '0;
        icell[0] = input_cell_a;
        icell[1] = input_cell_b;
        icell[3] = input_cell_d;
    end

    // per-port writable registers and pin logic
    for (genvar p = 0; p < iprb_pkg::NPORT; p++)
    begin : g_port
        always_ff @(posedge mclk)
        begin
            if (rst)
            begin
                latch_reg[p] <= iprb_pkg::RST_LATCH;
                dir_reg[p]   <= iprb_pkg::RST_DIR;
                drv_reg[p]   <= iprb_pkg::RST_DRV;
                func_reg[p]  <= iprb_pkg::RST_FUNC;
            end
            else if (wr_hit)
            begin
                if (bus_addr == iprb_pkg::OFS_LATCH[p])
                    latch_reg[p] <= bus_wdata;
                if (bus_addr == iprb_pkg::OFS_DIR[p])
                    dir_reg[p] <= bus_wdata;
                if (bus_addr == iprb_pkg::OFS_DRV[p])
                    drv_reg[p] <= bus_wdata;
                if (iprb_pkg::HAS_FUNC[p] && bus_addr == iprb_pkg::OFS_FUNC[p])
                    func_reg[p] <= bus_wdata;
            end
        end

        iprb_port_pin #(
            .W        (W),
            .HAS_OD   (iprb_pkg::HAS_OD[p]),
            .HAS_FUNC (iprb_pkg::HAS_FUNC[p])
        ) u_pin (
            .mclk      (mclk),
            .rst       (rst),
            .pin_in    (port_pin_in[p]),
            .latch     (latch_reg[p]),
            .dir       (dir_reg[p]),
            .drv       (drv_reg[p]),
            .func      (func_reg[p]),
            .addr_bits (latched_addr),
            .level     (level[p]),
            .pin_out   (port_pin_out[p]),
            .pin_oe    (port_pin_oe[p])
        );
    end

    // on ports c and f the driver type bit picks the fast edge instead
    assign slew_fast_c = drv_reg[2];
    assign slew_fast_f = drv_reg[5];

    // write guards for the two cell groups
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            guard_a_reg <= iprb_pkg::RST_GUARD;
            guard_b_reg <= iprb_pkg::RST_GUARD;
        end
        else if (wr_hit)
        begin
            if (bus_addr == iprb_pkg::OFS_GUARD_A)
                guard_a_reg <= bus_wdata;
            if (bus_addr == iprb_pkg::OFS_GUARD_B)
                guard_b_reg <= bus_wdata;
        end
    end

    iprb_out_cells #(
        .W (W)
    ) u_cells_a (
        .mclk     (mclk),
        .rst      (rst),
        .cpu_wr   (wr_hit && bus_addr == iprb_pkg::OFS_CELLS_A),
        .wdata    (bus_wdata),
        .guard    (guard_a_reg),
        .pld_load (pld_load_a),
        .pld_data (pld_data_a),
        .cells    (cells_a)
    );

    iprb_out_cells #(
        .W (W)
    ) u_cells_b (
        .mclk     (mclk),
        .rst      (rst),
        .cpu_wr   (wr_hit && bus_addr == iprb_pkg::OFS_CELLS_B),
        .wdata    (bus_wdata),
        .guard    (guard_b_reg),
        .pld_load (pld_load_b),
        .pld_data (pld_data_b),
        .cells    (cells_b)
    );

    // read mux; anything not matched falls through to zero
    always_comb
    begin
        rdata_next = iprb_pkg::RD_NONE;
        for (int p = 0; p < iprb_pkg::NPORT; p++)
        begin
            if (bus_addr == iprb_pkg::OFS_LEVEL[p])
                rdata_next = level[p];
            if (bus_addr == iprb_pkg::OFS_LATCH[p])
                rdata_next = latch_reg[p];
            if (bus_addr == iprb_pkg::OFS_DIR[p])
                rdata_next = dir_reg[p];
            if (bus_addr == iprb_pkg::OFS_DRV[p])
                rdata_next = drv_reg[p];
            if (iprb_pkg::HAS_FUNC[p] && bus_addr == iprb_pkg::OFS_FUNC[p])
                rdata_next = func_reg[p];
            if (iprb_pkg::HAS_ENST[p] && bus_addr == iprb_pkg::OFS_ENST[p])
                rdata_next = port_pin_oe[p];
            if (iprb_pkg::HAS_ICELL[p] && bus_addr == iprb_pkg::OFS_ICELL[p])
                rdata_next = icell[p];
        end
        if (bus_addr == iprb_pkg::OFS_CELLS_A)
            rdata_next = cells_a;
        if (bus_addr == iprb_pkg::OFS_CELLS_B)
            rdata_next = cells_b;
        if (bus_addr == iprb_pkg::OFS_GUARD_A)
            rdata_next = guard_a_reg;
        if (bus_addr == iprb_pkg::OFS_GUARD_B)
            rdata_next = guard_b_reg;
    end

    // read data is captured one edge after the strobe and held until the next read
    always_ff @(posedge mclk)
    begin
        if (rst)
            bus_rdata <= iprb_pkg::RD_NONE;
        else if (rd_hit)
            bus_rdata <= rdata_next;
    end

    // checks tied to the bus and the ports
    win_select_a: assert property (@(posedge mclk) disable iff (rst)
        !wr_hit |=> $stable(dir_reg) && $stable(latch_reg) && $stable(func_reg))
        else $error("register changed without a window write");
    level_read_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h30 |=> bus_rdata == $past(level[4]))
        else $error("pin level read wrong");
    latch_write_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h44 |=> latch_reg[5] == $past(bus_wdata))
        else $error("output latch not written");
    latch_drive_a: assert property (@(posedge mclk) disable iff (rst)
        dir_reg[2][3] && !drv_reg[2][3] |=> port_pin_oe[2][3]
            && port_pin_out[2][3] == $past(latch_reg[2][3]))
        else $error("output pin does not follow latch");
    dir_reset_a: assert property (@(posedge mclk)
        rst |=> dir_reg == '0 && port_pin_oe == '0)
        else $error("pins not inputs after reset");
    func_addr_a: assert property (@(posedge mclk) disable iff (rst)
        func_reg[6][1] |=> port_pin_oe[6][1]
            && port_pin_out[6][1] == $past(latched_addr[1]))
        else $error("address out mode wrong");
    func_none_a: assert property (@(posedge mclk) disable iff (rst)
        func_reg[3:0] == '0)
        else $error("function register on port without one");
    slew_write_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h48 |=> slew_fast_f == $past(bus_wdata))
        else $error("slew select not written");
    enst_read_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h1C |=> bus_rdata == $past(port_pin_oe[2]))
        else $error("driver enable readback wrong");
    cells_read_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h21 |=> bus_rdata == $past(cells_b))
        else $error("cell readback wrong");
    guard_hold_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h20 && guard_a_reg == 8'hFF
            |=> cells_a == $past(cells_a))
        else $error("guarded cells changed");
    ro_write_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h00 |=> $stable(latch_reg)
            && $stable(dir_reg) && $stable(drv_reg))
        else $error("write to read-only register had effect");
    unmapped_read_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && (bus_addr == 8'h02 || bus_addr == 8'hC0) |=> bus_rdata == 8'h00)
        else $error("unassigned offset read non-zero");

    // read data only moves on a read, so a slow cpu may pick it up late
    rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !rd_hit |=> $stable(bus_rdata))
        else $error("read data moved without a read");

    guard_sel_a: assert property (@(posedge mclk) disable iff (rst)
        !register_window_select |=> $stable(guard_a_reg) && $stable(guard_b_reg))
        else $error("guard changed without select");

    // pin level readback on the first and last port
    level_rd_a0_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h00 |=> bus_rdata == $past(level[0]))
        else $error("port a level read wrong");

    level_rd_g_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h41 |=> bus_rdata == $past(level[6]))
        else $error("port g level read wrong");

    icell_rd_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h0A |=> bus_rdata == $past(icell[0]))
        else $error("input cell read wrong");

    // writes land in the register of that offset only
    latch_wr_a_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h04 |=> latch_reg[0] == $past(bus_wdata))
        else $error("port a latch not written");

    latch_wr_e_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h34 |=> latch_reg[4] == $past(bus_wdata))
        else $error("port e latch not written");

    latch_rd_g_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h45 |=> bus_rdata == $past(latch_reg[6]))
        else $error("port g latch read wrong");

    dir_wr_a_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h06 |=> dir_reg[0] == $past(bus_wdata))
        else $error("port a direction not written");

    dir_wr_g_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h47 |=> dir_reg[6] == $past(bus_wdata))
        else $error("port g direction not written");

    dir_rd_d_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h17 |=> bus_rdata == $past(dir_reg[3]))
        else $error("port d direction read wrong");

    func_wr_e_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h32 |=> func_reg[4] == $past(bus_wdata))
        else $error("port e function not written");

    func_wr_g_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h43 |=> func_reg[6] == $past(bus_wdata))
        else $error("port g function not written");

    func_rd_f_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h42 |=> bus_rdata == $past(func_reg[5]))
        else $error("port f function read wrong");

    // with the function bit clear, open-drain drives low only and lets a one float
    od_release_a: assert property (@(posedge mclk) disable iff (rst)
        drv_reg[0][2] && dir_reg[0][2] && latch_reg[0][2] |=> !port_pin_oe[0][2])
        else $error("open-drain drove a one");

    od_low_a: assert property (@(posedge mclk) disable iff (rst)
        drv_reg[1][0] && dir_reg[1][0] && !latch_reg[1][0]
            |=> port_pin_oe[1][0] && !port_pin_out[1][0])
        else $error("open-drain did not pull low");

    drv_rd_e_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h38 |=> bus_rdata == $past(drv_reg[4]))
        else $error("port e driver type read wrong");

    drv_wr_a_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h08 |=> drv_reg[0] == $past(bus_wdata))
        else $error("port a driver type not written");

    slew_wr_c_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h18 |=> slew_fast_c == $past(bus_wdata))
        else $error("port c slew not written");

    // enable readback is the registered driver enable
    enst_rd_a_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h0C |=> bus_rdata == $past(port_pin_oe[0]))
        else $error("port a enable read wrong");

    enst_rd_f_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h4C |=> bus_rdata == $past(port_pin_oe[5]))
        else $error("port f enable read wrong");

    tri_default_a: assert property (@(posedge mclk) disable iff (rst)
        !dir_reg[0][0] |=> !port_pin_oe[0][0])
        else $error("input pin not tri-stated");

    cells_rd_a_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h20 |=> bus_rdata == $past(cells_a))
        else $error("group a cell read wrong");

    guard_rd_a_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && bus_addr == 8'h22 |=> bus_rdata == $past(guard_a_reg))
        else $error("group a guard read wrong");

    guard_wr_a_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h22 |=> guard_a_reg == $past(bus_wdata))
        else $error("group a guard not written");

    guard_wr_b_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h23 |=> guard_b_reg == $past(bus_wdata))
        else $error("group b guard not written");

    guard_b_hold_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h21 && guard_b_reg == 8'hFF
            |=> cells_b == $past(cells_b))
        else $error("guarded group b changed");

    cell_load_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h20 && guard_a_reg == 8'h00
            |=> cells_a == $past(bus_wdata))
        else $error("open cells not loaded");

    // read-only offsets leave every writable register alone
    ro_enst_a: assert property (@(posedge mclk) disable iff (rst)
        wr_hit && bus_addr == 8'h0C |=> $stable(latch_reg) && $stable(dir_reg)
            && $stable(drv_reg) && $stable(func_reg))
        else $error("write to enable readback had effect");

    unmapped_hi_a: assert property (@(posedge mclk) disable iff (rst)
        rd_hit && (bus_addr == 8'hE0 || bus_addr == 8'hF0) |=> bus_rdata == 8'h00)
        else $error("high unassigned offset read non-zero");
endmodule

// ===== tb/iprb_mcu_model.sv
// microcontroller bus model that reaches the register window byte by byte
`timescale 1ns/100ps
module iprb_mcu_model (
    input  wire logic       mclk,
    output logic            register_window_select,
    output logic [7:0]      bus_addr,
    output logic            bus_wr,
    output logic            bus_rd,
    output logic [7:0]      bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    // bus idle and deselected from time zero
    initial
    begin
        register_window_select = 1'b0;
        bus_addr = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end

    // one byte write at base plus offset, strobe held for one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
        @(posedge mclk);
        register_window_select <= sel;
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        register_window_select <= 1'b0;
        bus_wr <= 1'b0;
        bus_wdata <= ~d;        // stale data inverted so a lost write cannot match
    endtask

    // one byte read; data is registered, so it is picked up a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        register_window_select <= 1'b1;
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        register_window_select <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge mclk);
        #1;
        d = bus_rdata;
    endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the i/o port register bank
`timescale 1ns/100ps
module testbench;
    logic            mclk = 1'b0;
    logic            rst = 1'b1;
    logic            sel;
    logic [7:0]      addr;
    logic            wr;
    logic            rd;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic [6:0][7:0] pin_ext = '0;
    logic [6:0][7:0] pin_in;
    logic [6:0][7:0] pin_out;
    logic [6:0][7:0] pin_oe;
    logic [7:0]      slew_c;
    logic [7:0]      slew_f;
    logic [7:0]      laddr = 8'h00;
    logic [7:0]      icell_a = 8'h00;
    logic [7:0]      icell_b = 8'h00;
    logic [7:0]      icell_d = 8'h00;
    logic            ld_a = 1'b0;
    logic            ld_b = 1'b0;
    logic [7:0]      ld_data_a = 8'h00;
    logic [7:0]      ld_data_b = 8'h00;
    logic [7:0]      cells_a;
    logic [7:0]      cells_b;
    int              error_cnt = 0;
    int              n_compared = 0;

    always #4 mclk = ~mclk;

    // a released pin shows what the outside world puts on it
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);

    iprb_mcu_model mcu (.mclk(mclk), .register_window_select(sel), .bus_addr(addr),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata));

    iprb_bank dut (.mclk(mclk), .rst(rst), .register_window_select(sel), .bus_addr(addr),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata),
        .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .slew_fast_c(slew_c), .slew_fast_f(slew_f), .latched_addr(laddr),
        .input_cell_a(icell_a), .input_cell_b(icell_b), .input_cell_d(icell_d),
        .pld_load_a(ld_a), .pld_data_a(ld_data_a), .pld_load_b(ld_b),
        .pld_data_b(ld_data_b), .cells_a(cells_a), .cells_b(cells_b));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // covers pin register, driver and two synchroniser stages
    task automatic settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // a hang is cut short well past the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim;
    end

    initial
    begin : main
        int         p;
        logic [7:0] v;
        logic [7:0] d;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        // a write with the window deselected must not land
        mcu.wr(iprb_pkg::OFS_DIR[0], 8'hFF, 1'b0);
        settle;
        chk(pin_oe[0], 8'h00);
        // every port: levels, latch, direction, driver type, function
        for (p = 0; p < 7; p++)
        begin
            v = 8'h5A ^ 8'(p);
            pin_ext[p] <= v;
            settle;
            mcu.rd(iprb_pkg::OFS_LEVEL[p], d);
            chk(d, v);
            mcu.wr(iprb_pkg::OFS_LEVEL[p], 8'h00, 1'b1);
            mcu.rd(iprb_pkg::OFS_LEVEL[p], d);
            chk(d, v);
            mcu.rd(iprb_pkg::OFS_DIR[p], d);
            chk(d, 8'h00);
            mcu.rd(iprb_pkg::OFS_DRV[p], d);
            chk(d, 8'h00);
            mcu.wr(iprb_pkg::OFS_LATCH[p], 8'hA5, 1'b1);
            mcu.wr(iprb_pkg::OFS_DIR[p], 8'hFF, 1'b1);
            settle;
            chk(pin_oe[p], 8'hFF);
            chk(pin_out[p], 8'hA5);
            mcu.rd(iprb_pkg::OFS_LEVEL[p], d);
            chk(d, 8'hA5);
            if (iprb_pkg::HAS_ENST[p])
            begin
                mcu.rd(iprb_pkg::OFS_ENST[p], d);
                chk(d, 8'hFF);
            end
            // low nibble: open-drain releases the ones, slew ports keep driving
            mcu.wr(iprb_pkg::OFS_DRV[p], 8'h0F, 1'b1);
            settle;
            if (iprb_pkg::HAS_OD[p])
            begin
                chk(pin_oe[p], 8'hFA);
                chk(pin_out[p] & pin_oe[p], 8'hA0);
                mcu.rd(iprb_pkg::OFS_DRV[p], d);
                chk(d, 8'h0F);
            end
            else
            begin
                chk(pin_oe[p], 8'hFF);
                chk((p == 2) ? slew_c : slew_f, 8'h0F);
            end
            if (iprb_pkg::HAS_FUNC[p])
            begin
                mcu.rd(iprb_pkg::OFS_FUNC[p], d);
                chk(d, 8'h00);
                laddr <= 8'h3C;
                mcu.wr(iprb_pkg::OFS_FUNC[p], 8'hFF, 1'b1);
                settle;
                chk(pin_oe[p], 8'hFF);
                chk(pin_out[p], 8'h3C);
                mcu.wr(iprb_pkg::OFS_FUNC[p], 8'h00, 1'b1);
            end
            mcu.wr(iprb_pkg::OFS_DIR[p], 8'h00, 1'b1);
            settle;
            chk(pin_oe[p], 8'h00);
            if (iprb_pkg::HAS_ENST[p])
            begin
                mcu.rd(iprb_pkg::OFS_ENST[p], d);
                chk(d, 8'h00);
            end
        end
        // input cell readback is read-only
        icell_a <= 8'h81;
        icell_b <= 8'h42;
        icell_d <= 8'h24;
        mcu.wr(iprb_pkg::OFS_ICELL[0], 8'h00, 1'b1);
        mcu.rd(iprb_pkg::OFS_ICELL[0], d);
        chk(d, 8'h81);
        mcu.rd(iprb_pkg::OFS_ICELL[1], d);
        chk(d, 8'h42);
        mcu.rd(iprb_pkg::OFS_ICELL[3], d);
        chk(d, 8'h24);
        // output cells: guarded bits keep their old value
        mcu.rd(iprb_pkg::OFS_CELLS_A, d);
        chk(d, 8'h00);
        mcu.wr(iprb_pkg::OFS_GUARD_A, 8'h0F, 1'b1);
        mcu.wr(iprb_pkg::OFS_CELLS_A, 8'hA5, 1'b1);
        settle;
        chk(cells_a, 8'hA0);
        mcu.rd(iprb_pkg::OFS_CELLS_A, d);
        chk(d, 8'hA0);
        mcu.rd(iprb_pkg::OFS_GUARD_A, d);
        chk(d, 8'h0F);
        mcu.wr(iprb_pkg::OFS_GUARD_B, 8'hF0, 1'b1);
        mcu.wr(iprb_pkg::OFS_CELLS_B, 8'hFF, 1'b1);
        settle;
        chk(cells_b, 8'h0F);
        // the array loads cells regardless of the cpu guard
        ld_a <= 1'b1;
        ld_data_a <= 8'h3C;
        @(posedge mclk);
        ld_a <= 1'b0;
        ld_b <= 1'b1;
        ld_data_b <= 8'hC3;
        @(posedge mclk);
        ld_b <= 1'b0;
        settle;
        chk(cells_a, 8'h3C);
        chk(cells_b, 8'hC3);
        // unassigned offsets read zero even after a write
        mcu.wr(8'h02, 8'hFF, 1'b1);
        mcu.rd(8'h02, d);
        chk(d, 8'h00);
        mcu.rd(8'hC0, d);
        chk(d, 8'h00);
        end_sim;
    end
endmodule
